// ### rtl/sfs_host.sv
// Contract
// - Every program starts with the same three-write protection sequence.
// - Host loads a byte pulsing write strobe, chip select low, gate high.
// - Next load falling edge within 150 us, else programming starts.
// - Host keeps sector number valid at every load falling edge.
`timescale 1ns/1ps
module sfs_host #(
	parameter int                         POWER_ON_CYC    = sfs_pkg::POWER_ON_CYC,
	parameter int                         PROGRAM_CYC     = sfs_pkg::PROGRAM_CYC,
	parameter int                         LOAD_WINDOW_CYC = sfs_pkg::LOAD_WINDOW_CYC,
	parameter logic [sfs_pkg::ADDR_W-1:0] PROT_ADDR0      = 15'h0001,
	parameter logic [sfs_pkg::ADDR_W-1:0] PROT_ADDR1      = 15'h0002,
	parameter logic [sfs_pkg::ADDR_W-1:0] PROT_ADDR2      = 15'h0003,
	parameter logic [sfs_pkg::DATA_W-1:0] PROT_DATA0      = 8'h01,
	parameter logic [sfs_pkg::DATA_W-1:0] PROT_DATA1      = 8'h02,
	parameter logic [sfs_pkg::DATA_W-1:0] PROT_DATA2      = 8'h03
) (
	input  wire logic                         clock,
	input  wire logic                         rst,
	input  wire logic                         poll_by_toggle,
	input  wire logic                         req_valid,
	output logic                              req_ready,
	input  wire sfs_pkg::sfs_req_t            req,
	input  wire logic                         load_valid,
	output logic                              load_ready,
	input  wire sfs_pkg::sfs_load_t           load,
	output logic                              resp_valid,
	output sfs_pkg::sfs_resp_t                resp,
	output sfs_pkg::sfs_pins_t                pins,
	input  wire logic [sfs_pkg::DATA_W-1:0]   dq_in
);

	typedef enum logic [3:0] {
		ST_POWER_UP,
		ST_IDLE,
		ST_READ,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_LOAD,
		ST_POLL_READ,
		ST_POLL_GAP,
		ST_ANSWER
	} sfs_state_t;

	typedef struct packed {
		sfs_state_t                        st;
		logic [31:0]                       cnt;
		logic [31:0]                       timer;
		logic [1:0]                        cmd_idx;
		logic                              loading;
		logic                              last_write;
		logic [sfs_pkg::SECTOR_W-1:0]      sector;
		logic [sfs_pkg::ADDR_W-1:0]        last_addr;
		logic [sfs_pkg::DATA_W-1:0]        last_data;
		logic                              toggle_have;
		logic                              toggle_prev;
		sfs_pkg::sfs_pins_t                pins;
		sfs_pkg::sfs_resp_t                resp;
		logic                              resp_valid;
	} sfs_ctl_t;

	sfs_ctl_t                       cur;
	sfs_ctl_t                       next_cur;
	logic [sfs_pkg::DATA_W-1:0]     dq_sync;

	localparam logic [31:0] READ_WAIT  = 32'(sfs_pkg::READ_CYC + sfs_pkg::SYNC_CYC);
	localparam logic [31:0] SETUP_WAIT = 32'(sfs_pkg::SETUP_CYC);
	localparam logic [31:0] PULSE_WAIT = 32'(sfs_pkg::PULSE_CYC);
	// A byte taken at the guard still drops its strobe setup+2 cycles later, so stop 4*setup cycles early.
	localparam logic [31:0] LOAD_GUARD = 32'(LOAD_WINDOW_CYC - 4 * sfs_pkg::SETUP_CYC);

	// Read data comes back from the flash pins asynchronously.
	sfs_sync3 #(
		.W(sfs_pkg::DATA_W)
	) u_dq_sync (
		.clock    (clock),
		.rst      (rst),
		.async_in (dq_in),
		.sync_out (dq_sync)
	);

	// Handshakes are combinational from the current state.
	assign req_ready  = (cur.st == ST_IDLE);
	assign load_ready = (cur.st == ST_LOAD) && !cur.last_write && (cur.timer < LOAD_GUARD);
	assign resp_valid = cur.resp_valid;
	assign resp       = cur.resp;
	assign pins       = cur.pins;

	// Next-state logic for the whole controller.
	always_comb begin
		next_cur            = cur;
		next_cur.resp_valid = 1'b0;
		next_cur.cnt        = cur.cnt + 32'h1;
		next_cur.timer      = cur.timer + 32'h1;
		unique case (cur.st)
			ST_POWER_UP: begin
				if (cur.timer >= 32'(POWER_ON_CYC)) begin
					next_cur.st = ST_IDLE;
				end
			end
			ST_IDLE: begin
				next_cur.pins.chip_select_n  = 1'b1;
				next_cur.pins.output_gate_n  = 1'b1;
				next_cur.pins.write_strobe_n = 1'b1;
				next_cur.pins.dq_oe          = 1'b0;
				if (req_valid) begin
					next_cur.cnt  = 32'h0;
					next_cur.resp = '0;
					if (req.op == sfs_pkg::SFS_OP_READ) begin
						next_cur.st                 = ST_READ;
						next_cur.pins.addr          = req.addr;
						next_cur.pins.chip_select_n = 1'b0;
						next_cur.pins.output_gate_n = 1'b0;
					end else begin
						next_cur.st          = ST_WR_SETUP;
						next_cur.sector      = req.addr[sfs_pkg::ADDR_W-1:sfs_pkg::BYTE_W];
						next_cur.cmd_idx     = 2'h0;
						next_cur.loading     = 1'b0;
						next_cur.last_write  = 1'b0;
						next_cur.pins.addr   = PROT_ADDR0;
						next_cur.pins.dq_out = PROT_DATA0;
					end
				end
			end
			ST_READ: begin
				if (cur.cnt >= READ_WAIT) begin
					next_cur.resp.data          = dq_sync;
					next_cur.pins.chip_select_n = 1'b1;
					// release the gate so the flash floats
					next_cur.pins.output_gate_n = 1'b1;
					next_cur.st                 = ST_ANSWER;
				end
			end
			// select low, gate high, data driven before the strobe falls
			ST_WR_SETUP: begin
				next_cur.pins.chip_select_n  = 1'b0;
				next_cur.pins.output_gate_n  = 1'b1;
				next_cur.pins.dq_oe          = 1'b1;
				if (cur.cnt >= SETUP_WAIT) begin
					next_cur.cnt                 = 32'h0;
					// strobe falls last, address already stable
					next_cur.pins.write_strobe_n = 1'b0;
					next_cur.st                  = ST_WR_PULSE;
				end
			end
			// pulse held far beyond the noise-filter width
			ST_WR_PULSE: begin
				if (cur.cnt >= PULSE_WAIT) begin
					next_cur.cnt                 = 32'h0;
					// strobe rises first, data still held
					next_cur.pins.write_strobe_n = 1'b1;
					next_cur.st                  = ST_WR_HOLD;
				end
			end
			ST_WR_HOLD: begin
				if (cur.cnt >= SETUP_WAIT) begin
					next_cur.cnt                = 32'h0;
					next_cur.timer              = 32'h0;
					next_cur.pins.dq_oe         = 1'b0;
					next_cur.pins.chip_select_n = 1'b1;
					if (!cur.loading && cur.cmd_idx != 2'h2) begin
						next_cur.cmd_idx     = cur.cmd_idx + 2'h1;
						next_cur.pins.addr   = (cur.cmd_idx == 2'h0) ? PROT_ADDR1 : PROT_ADDR2;
						next_cur.pins.dq_out = (cur.cmd_idx == 2'h0) ? PROT_DATA1 : PROT_DATA2;
						next_cur.st          = ST_WR_SETUP;
					end else begin
						// After the last byte the host still sits out the load window.
						next_cur.loading = 1'b1;
						next_cur.st      = ST_LOAD;
					end
				end
			end
			// keep each load inside the window
			ST_LOAD: begin
				if (load_valid && load_ready) begin
					next_cur.cnt = 32'h0;
					// sector number on the upper lines
					// user index picks the byte, any order
					next_cur.pins.addr   = {cur.sector, load.index};
					next_cur.pins.dq_out = load.data;
					next_cur.last_addr   = {cur.sector, load.index};
					next_cur.last_data   = load.data;
					next_cur.last_write  = load.last;
					next_cur.st          = ST_WR_SETUP;
				end else if (cur.timer >= 32'(LOAD_WINDOW_CYC)) begin
					// Polling before the window closes would read old data as if programming were done.
					next_cur.resp.short_load = !cur.last_write;
					next_cur.toggle_have     = 1'b0;
					next_cur.timer           = 32'h0;
					next_cur.cnt             = 32'h0;
					next_cur.st              = ST_POLL_READ;
				end
			end
			ST_POLL_READ: begin
				next_cur.pins.addr          = cur.last_addr;
				next_cur.pins.chip_select_n = 1'b0;
				next_cur.pins.output_gate_n = 1'b0;
				if (cur.cnt >= READ_WAIT) begin
					next_cur.cnt                = 32'h0;
					next_cur.pins.output_gate_n = 1'b1;
					next_cur.pins.chip_select_n = 1'b1;
					next_cur.resp.data          = dq_sync;
					next_cur.st                 = ST_POLL_GAP;
					next_cur.toggle_have        = 1'b1;
					next_cur.toggle_prev        = dq_sync[sfs_pkg::TOGGLE_BIT];
					if (poll_by_toggle) begin
						// bit six stops toggling when done
						if (cur.toggle_have &&
						    cur.toggle_prev == dq_sync[sfs_pkg::TOGGLE_BIT]) begin
							next_cur.st = ST_ANSWER;
						end
					end else if (dq_sync[sfs_pkg::POLL_BIT] ==
					             cur.last_data[sfs_pkg::POLL_BIT]) begin
						// true data means the cycle has ended
						next_cur.st = ST_ANSWER;
					end
				end
			end
			// Separate reads are needed so each one counts as a new access for the toggle.
			ST_POLL_GAP: begin
				if (cur.timer >= 32'(PROGRAM_CYC)) begin
					// give up after the longest cycle time
					next_cur.resp.timeout = 1'b1;
					next_cur.st           = ST_ANSWER;
				end else if (cur.cnt >= SETUP_WAIT) begin
					next_cur.cnt = 32'h0;
					next_cur.st  = ST_POLL_READ;
				end
			end
			ST_ANSWER: begin
				next_cur.resp_valid = 1'b1;
				next_cur.st         = ST_IDLE;
			end
		endcase
	end

	// Reset counts as power-up, so the power-on wait always runs again.
	always_ff @(posedge clock) begin
		if (rst) begin
			cur                     <= '0;
			cur.st                  <= ST_POWER_UP;
			cur.pins.chip_select_n  <= 1'b1;
			cur.pins.output_gate_n  <= 1'b1;
			cur.pins.write_strobe_n <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

endmodule

// ### rtl/sfs_pkg.sv
package sfs_pkg;

	// Clock rate of the controller, in MHz (200 MHz, 5 ns period).
	localparam int CLK_MHZ = 200;

	// Array geometry seen through the pins.
	localparam int ADDR_W       = 15;
	localparam int DATA_W       = 8;
	localparam int BYTE_W       = 6;
	localparam int SECTOR_W     = 9;
	localparam int SECTOR_BYTES = 64;
	localparam int SECTORS      = 512;

	// Bit positions of the completion flags in a read byte.
	localparam int POLL_BIT   = 7;
	localparam int TOGGLE_BIT = 6;

	// Times as printed or chosen, each in its own unit.
	localparam int T_READ_ACCESS_NS = 200;
	localparam int T_WRITE_SETUP_NS = 20;
	localparam int T_WRITE_PULSE_NS = 100;
	localparam int T_LOAD_WINDOW_US = 150;
	localparam int T_POWER_ON_MS    = 10;
	localparam int T_PROGRAM_MS     = 20;

	// Least times round up to whole cycles.
	localparam int READ_CYC  = (T_READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int SETUP_CYC = (T_WRITE_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_CYC = (T_WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int POWER_ON_CYC = T_POWER_ON_MS * CLK_MHZ * 1000;
	localparam int PROGRAM_CYC  = T_PROGRAM_MS * CLK_MHZ * 1000;
	// Longest time rounds down.
	localparam int LOAD_WINDOW_CYC = T_LOAD_WINDOW_US * CLK_MHZ;

	// Extra cycles the three-stage input synchroniser adds to a read.
	localparam int SYNC_CYC = 3;

	// Operations a user may request.
	typedef enum logic {
		SFS_OP_READ,
		SFS_OP_PROGRAM
	} sfs_op_t;

	// Pins driven towards the flash.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              chip_select_n;
		logic              output_gate_n;
		logic              write_strobe_n;
		logic [DATA_W-1:0] dq_out;
		logic              dq_oe;
	} sfs_pins_t;

	// One user request; for a program the upper address bits name the sector.
	typedef struct packed {
		sfs_op_t           op;
		logic [ADDR_W-1:0] addr;
	} sfs_req_t;

	// One byte handed in during the load period.
	typedef struct packed {
		logic [BYTE_W-1:0] index;
		logic [DATA_W-1:0] data;
		logic              last;
	} sfs_load_t;

	// Answer to a request.
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              timeout;
		logic              short_load;
	} sfs_resp_t;

endpackage

// ### rtl/sfs_sync3.sv
`timescale 1ns/1ps
module sfs_sync3 #(
	parameter int W = 8
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	// Each bit passes four flops; a change is taken once stages two and three agree.
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic [2:0] stage;
		always_ff @(posedge clock) begin
			if (rst) begin
				stage       <= 3'h0;
				sync_out[i] <= 1'b0;
			end else begin
				stage <= {stage[1:0], async_in[i]};
				if (stage[1] == stage[2]) begin
					sync_out[i] <= stage[2];
				end
			end
		end
	end

endmodule

// ### tb/sfs_flash_model.sv
`timescale 1ns/1ps
module sfs_flash_model #(
	parameter int WIN  = 30,
	parameter int BUSY = 600
) (
	input  wire logic               clock,
	input  wire sfs_pkg::sfs_pins_t pins,
	output logic [7:0]              dq
);
	localparam logic [14:0] PA [3] = '{15'h0001, 15'h0002, 15'h0003};
	localparam logic [7:0]  PD [3] = '{8'h01, 8'h02, 8'h03};
	logic [7:0]  mem [32768];
	logic [7:0]  buf_d [64];
	logic [63:0] mask = '0;
	logic [14:0] a;
	logic [8:0]  sec;
	logic [7:0]  ld = '0;
	logic        wr;
	logic        rd;
	logic        wr_q = 0;
	logic        rd_q = 0;
	logic        tog = 0;
	logic        lding = 0;
	// no power reset
	// The model has no reset pin, so a controller reset never clears this count.
	int          prot = 0;
	int          win = 0;
	int          busy = 0;

	assign wr = !pins.chip_select_n && !pins.write_strobe_n && pins.output_gate_n;
	assign rd = !pins.chip_select_n && !pins.output_gate_n && pins.write_strobe_n;

	// A known pattern lets reads before any program be predicted.
	initial begin
		dq = '0;
		for (int i = 0; i < 32768; i++)
			mem[i] = 8'(i) ^ 8'h5a;
	end

	// Runs on the falling edge so the host's registered pins have settled.
	always @(negedge clock) begin
		if (wr && !wr_q)
			a = pins.addr;
		if (!wr && wr_q && busy == 0) begin
			ld = pins.dq_out;
			if (prot == 3) begin
				buf_d[a[5:0]] = ld;
				mask[a[5:0]] = 1'b1;
				sec = a[14:6];
				lding = 1'b1;
				win = 0;
			end else if (a == PA[prot] && ld == PD[prot])
				prot++;
			else begin
				prot = 0;
				busy = BUSY;
			end
		end
		if (lding)
			win++;
		if (lding && win >= WIN) begin
			for (int i = 0; i < 64; i++)
				mem[{sec, 6'(i)}] = mask[i] ? buf_d[i] : 8'hff;
			lding = 1'b0;
			mask = '0;
			prot = 0;
			busy = BUSY;
		end else if (busy > 0)
			busy--;
		if (rd && !rd_q)
			tog = ~tog;
		if (!rd)
			dq <= ~dq;
		else if (busy > 0)
			dq <= {~ld[7], tog, ld[5:0]};
		// true data
		// Identification mode is never entered, since the controller sends no entry sequence.
		else
			dq <= mem[pins.addr];
		wr_q = wr;
		rd_q = rd;
	end
endmodule

// ### tb/sfs_host_monitor.sv
`timescale 1ns/1ps
module sfs_host_monitor #(
	parameter int POWER_ON_CYC = 20
) (
	input wire logic               clock,
	input wire logic               rst,
	input wire logic               req_valid,
	input wire logic               req_ready,
	input wire logic               resp_valid,
	input wire sfs_pkg::sfs_pins_t pins
);
	int unsigned up_cnt;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Cycles since reset release, capped so the counter never wraps.
	always_ff @(posedge clock) begin
		if (rst)
			up_cnt <= 0;
		else if (up_cnt < POWER_ON_CYC)
			up_cnt <= up_cnt + 1;
	end

	power_on_wait_a: assert property (
		req_ready |-> up_cnt == POWER_ON_CYC) else $error("request accepted too early");
	strobe_select_a: assert property (
		!pins.write_strobe_n |-> !pins.chip_select_n && pins.output_gate_n && pins.dq_oe)
		else $error("strobe low outside a write");
	load_addr_hold_a: assert property (
		!pins.write_strobe_n && $past(!pins.write_strobe_n) |-> $stable(pins.addr))
		else $error("address moved during strobe");
	data_past_rise_a: assert property (
		$rose(pins.write_strobe_n) |-> pins.dq_oe && !pins.chip_select_n && $stable(pins.dq_out))
		else $error("data not held at strobe rise");
	addr_hold_select_a: assert property (
		!pins.chip_select_n && $past(!pins.chip_select_n) |-> $stable(pins.addr))
		else $error("address moved while selected");
	strobe_width_a: assert property (
		$fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*8]) else $error("strobe too short");
	no_contention_a: assert property (
		!pins.output_gate_n |-> !pins.dq_oe && pins.write_strobe_n)
		else $error("host drives data while reading");
	read_access_a: assert property (
		$fell(pins.output_gate_n) |-> (!pins.output_gate_n && !pins.chip_select_n) [*8])
		else $error("read access cut short");
	take_to_select_a: assert property (
		req_valid && req_ready |-> ##1 !req_ready ##[0:4] !pins.chip_select_n)
		else $error("request did not start an access");
	resp_pulse_a: assert property (
		resp_valid |=> !resp_valid) else $error("response longer than one cycle");
endmodule

bind sfs_host sfs_host_monitor #(.POWER_ON_CYC(POWER_ON_CYC)) mon_u (
	.clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
	.resp_valid(resp_valid), .pins(pins));

// ### tb/sfs_host_tb.sv
`timescale 1ns/1ps
module sfs_host_tb;
	logic               clock = 0;
	logic               rst = 1;
	logic               poll_by_toggle = 0;
	logic               req_valid = 0;
	logic               load_valid = 0;
	logic               req_ready;
	logic               load_ready;
	logic               resp_valid;
	sfs_pkg::sfs_req_t  req = '0;
	sfs_pkg::sfs_load_t load = '0;
	sfs_pkg::sfs_resp_t resp;
	sfs_pkg::sfs_pins_t pins;
	logic [7:0]         dq;
	int                 err_count = 0;
	int                 checked = 0;
	int                 cyc = 0;

	always #2.5 clock = ~clock;

	sfs_host #(.POWER_ON_CYC(20), .PROGRAM_CYC(2000), .LOAD_WINDOW_CYC(200)) dut_u (
		.clock(clock), .rst(rst), .poll_by_toggle(poll_by_toggle), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .load_valid(load_valid), .load_ready(load_ready),
		.load(load), .resp_valid(resp_valid), .resp(resp), .pins(pins), .dq_in(dq));
	sfs_flash_model #(.WIN(200), .BUSY(600)) flash_u (.clock(clock), .pins(pins), .dq(dq));

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: byte %h wanted %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: flag %b wanted %b", $time, got, exp);
		end
	endtask

	// Requests are held until ready is seen, so the take edge is never missed.
	task automatic start(input sfs_pkg::sfs_op_t op, input logic [14:0] addr);
		@(posedge clock);
		req_valid <= 1'b1;
		req <= '{op: op, addr: addr};
		do @(negedge clock); while (req_ready !== 1'b1);
		@(posedge clock);
		req_valid <= 1'b0;
	endtask

	task automatic put(input logic [5:0] idx, input logic [7:0] d, input logic last);
		@(posedge clock);
		load_valid <= 1'b1;
		load <= '{index: idx, data: d, last: last};
		do @(negedge clock); while (load_ready !== 1'b1);
		@(posedge clock);
		load_valid <= 1'b0;
	endtask

	task automatic wait_resp();
		do @(negedge clock); while (resp_valid !== 1'b1);
	endtask

	task automatic read_chk(input logic [14:0] addr, input logic [7:0] exp);
		start(sfs_pkg::SFS_OP_READ, addr);
		wait_resp();
		check_byte(resp.data, exp);
	endtask

	task automatic test_power_on();
		int n;
		n = 0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		do begin
			@(negedge clock);
			n++;
		end while (req_ready !== 1'b1);
		check_bit(n >= 20, 1'b1);
		$display("test power_on done");
	endtask

	task automatic test_read();
		read_chk(15'h0123, 8'h79);
		read_chk(15'h7fff, 8'ha5);
		$display("test read done");
	endtask

	// Bytes go in out of order; the old last byte has the other bit 7.
	task automatic test_program();
		start(sfs_pkg::SFS_OP_PROGRAM, 15'h0140);
		put(6'd9, 8'ha1, 1'b0);
		put(6'd2, 8'h3c, 1'b0);
		put(6'd63, 8'hc7, 1'b1);
		wait_resp();
		check_byte(resp.data, 8'hc7);
		check_bit(resp.short_load, 1'b0);
		check_bit(resp.timeout, 1'b0);
		read_chk(15'h0149, 8'ha1);
		read_chk(15'h0142, 8'h3c);
		read_chk(15'h0140, 8'hff);
		$display("test program done");
	endtask

	task automatic test_toggle();
		@(posedge clock);
		poll_by_toggle <= 1'b1;
		start(sfs_pkg::SFS_OP_PROGRAM, 15'h0180);
		put(6'd0, 8'h80, 1'b1);
		wait_resp();
		check_byte(resp.data, 8'h80);
		read_chk(15'h0181, 8'hff);
		read_chk(15'h0180, 8'h80);
		@(posedge clock);
		poll_by_toggle <= 1'b0;
		$display("test toggle done");
	endtask

	// The host stalls after one byte, so the window has to close the load.
	task automatic test_short_load();
		start(sfs_pkg::SFS_OP_PROGRAM, 15'h01c0);
		put(6'd4, 8'h11, 1'b0);
		wait_resp();
		check_bit(resp.short_load, 1'b1);
		check_byte(resp.data, 8'h11);
		read_chk(15'h01c4, 8'h11);
		read_chk(15'h01c5, 8'hff);
		$display("test short_load done");
	endtask

	// A hang is cut short well beyond the expected run length.
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			$display("unexpected at %0t: run too long", $time);
			complete_run();
		end
	end

	initial begin
		test_power_on();
		test_read();
		test_program();
		test_toggle();
		test_short_load();
		complete_run();
	end
endmodule
